/* File: rtl/insn_decoder.sv */
// instruction decoder top: registers the class, length and variant fields
`timescale 1ns/100ps
`default_nettype none
module insn_decoder #(
	parameter int GPR_IDX_W = 4
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  insn_valid_i,
	input  wire logic [31:0]           insn_i,
	output var  logic                  dec_valid_o,
	output var  logic                  illegal_o,
	output var  decoder_pkg::op_class_t dec_class_o,
	output var  logic [2:0]            len_bytes_o,
	output var  logic                  byte_op_o,
	output var  logic                  variant_o,
	output var  logic [3:0]            sub_kind_o,
	output var  logic                  with_carry_o,
	output var  logic                  signed_op_o,
	output var  logic                  dividend_pair_o,
	output var  logic [1:0]            step_o,
	output var  logic                  sign_fill_o,
	output var  logic                  bit_alter_o,
	output var  logic                  no_effect_o,
	output var  logic [GPR_IDX_W-1:0]  reg_a_o,
	output var  logic [GPR_IDX_W-1:0]  reg_b_o,
	output var  logic [15:0]           operand_o
);
	import decoder_pkg::*;

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (GPR_IDX_W < 1 || GPR_IDX_W > 4) begin : g_bad_width
		$error("register index width must be 1 to 4");
	end

	// ------------------------------------------------------------
	// lookup stages
	// ------------------------------------------------------------
	decode_if dif ();

	assign dif.opcode = insn_i[7:0];
	assign dif.arg    = insn_i[ARG_MSB:ARG_LSB];

	class_lookup u_class (
		.dif (dif.lookup_mp)
	);

	variant_decode u_variant (
		.dif (dif.variant_mp)
	);

	logic legal;
	logic long_form;

	// both bytes must fit the instruction set
	assign legal     = dif.class_ok && dif.field_ok;
	assign long_form = dif.len4;

	// ------------------------------------------------------------
	// handshake flags
	// ------------------------------------------------------------
	// illegal opcodes never reach execution
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dec_valid_o <= 1'b0;
			illegal_o   <= 1'b0;
		end else begin
			dec_valid_o <= insn_valid_i && legal;
			illegal_o   <= insn_valid_i && !legal;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			len_bytes_o <= LEN_SHORT;
		end else if (insn_valid_i) begin
			len_bytes_o <= long_form ? LEN_LONG : LEN_SHORT;
		end
	end

	// ------------------------------------------------------------
	// decoded fields
	// ------------------------------------------------------------
	// class and raw variant bits
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dec_class_o <= cls_nop;
			byte_op_o   <= 1'b0;
			variant_o   <= 1'b0;
			sub_kind_o  <= 4'h0;
		end else if (insn_valid_i) begin
			dec_class_o <= dif.cls;
			byte_op_o   <= insn_i[ARG_SIZE_BIT + ARG_LSB] &&
				(dif.cls != cls_coproc);
			variant_o   <= dif.alt;
			sub_kind_o  <= dif.sub_kind;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			with_carry_o    <= 1'b0;
			signed_op_o     <= 1'b0;
			dividend_pair_o <= 1'b0;
		end else if (insn_valid_i) begin
			with_carry_o    <= dif.with_carry;
			signed_op_o     <= dif.signed_op;
			dividend_pair_o <= dif.dividend_pair;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			step_o      <= 2'h0;
			sign_fill_o <= 1'b0;
			bit_alter_o <= 1'b0;
			no_effect_o <= 1'b0;
		end else if (insn_valid_i) begin
			step_o      <= dif.step;
			sign_fill_o <= dif.sign_fill;
			bit_alter_o <= dif.bit_alter;
			no_effect_o <= dif.no_effect;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_a_o   <= '0;
			reg_b_o   <= '0;
			operand_o <= 16'h0000;
		end else if (insn_valid_i) begin
			reg_a_o   <= insn_i[REG_A_LSB +: GPR_IDX_W];
			reg_b_o   <= long_form ? insn_i[REG_B_LSB +: GPR_IDX_W] : '0;
			operand_o <= long_form ? insn_i[OPND_MSB:OPND_LSB] : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_ARITH_FORMS: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && (dif.cls == cls_add || dif.cls == cls_sub)
		|=> dec_valid_o && with_carry_o == $past(insn_i[OPC_ALT_BIT]) &&
			len_bytes_o == ($past(insn_i[OPC_LONG_BIT]) ? LEN_LONG
				: LEN_SHORT))
		else $error("add or subtract form decoded wrongly");

	AST_PRODUCT_SIGN: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_product
		|=> signed_op_o != $past(insn_i[OPC_ALT_BIT]) &&
			len_bytes_o == LEN_LONG)
		else $error("product signedness wrong");

	AST_SHORT_QUOT: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_short_quot
		|=> len_bytes_o == LEN_SHORT && !dividend_pair_o)
		else $error("short divide decoded wrongly");

	AST_LONG_QUOT: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_long_quot
		|=> len_bytes_o == LEN_SHORT && dividend_pair_o)
		else $error("long divide decoded wrongly");

	AST_COMPLEMENT_LEN: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal &&
		(dif.cls == cls_ones_compl || dif.cls == cls_twos_compl)
		|=> len_bytes_o == LEN_SHORT && dec_valid_o)
		else $error("complement length wrong");

	AST_BIT_COPY: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_bit_copy
		|=> len_bytes_o == LEN_LONG && bit_alter_o == $past(dif.alt))
		else $error("bit copy decoded wrongly");

	AST_STEP_SIZE: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal &&
		(dif.cls == cls_cmp_dec || dif.cls == cls_cmp_inc)
		|=> step_o == ($past(insn_i[OPC_ALT_BIT]) ? STEP_TWO : STEP_ONE))
		else $error("compare step size wrong");

	AST_SIGN_FILL: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_byte_extend
		|=> sign_fill_o == !$past(insn_i[OPC_ALT_BIT]))
		else $error("byte extension fill wrong");

	AST_LEGACY_IDLE: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && dif.cls == cls_system && dif.class_ok &&
		!dif.arg[ARG_SIZE_BIT] && dif.sub_kind == SYS_LEGACY_PD
		|=> dec_valid_o && no_effect_o && len_bytes_o == LEN_LONG)
		else $error("legacy power-down not a valid no-op");

	AST_COP_LEN: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_coproc
		|=> dec_valid_o && len_bytes_o == LEN_LONG)
		else $error("coprocessor length not four");

	AST_ILLEGAL: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && !legal
		|=> illegal_o && !dec_valid_o)
		else $error("unsupported opcode not flagged");

	AST_LEN_FIRST_BYTE: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i ##1 insn_valid_i &&
		insn_i[7:0] == $past(insn_i[7:0])
		|=> len_bytes_o == $past(len_bytes_o))
		else $error("length depends on more than first byte");

	AST_MASKED_FIELD: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_masked_field
		|=> len_bytes_o == LEN_LONG && !bit_alter_o)
		else $error("masked field decoded wrongly");

	AST_STEP_OTHER: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && dif.cls != cls_cmp_dec && dif.cls != cls_cmp_inc
		|=> step_o == 2'h0)
		else $error("step on non-stepping class");

	AST_NORM_COUNT: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_norm_count
		|=> len_bytes_o == LEN_LONG &&
			reg_b_o == $past(insn_i[REG_B_LSB +: GPR_IDX_W]))
		else $error("normalise count decoded wrongly");

	AST_SIGNED_SHR: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_signed_shr
		|=> len_bytes_o == LEN_SHORT && sign_fill_o)
		else $error("signed shift decoded wrongly");

	AST_BR_SET_BIT: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_br_set_bit
		|=> len_bytes_o == LEN_LONG && bit_alter_o == $past(dif.alt))
		else $error("branch on set bit decoded wrongly");

	AST_BR_CLR_BIT: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_br_clr_bit
		|=> len_bytes_o == LEN_LONG && bit_alter_o == $past(dif.alt))
		else $error("branch on clear bit decoded wrongly");

	AST_PUSH_CALL: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_push_call
		|=> len_bytes_o == LEN_LONG &&
			operand_o == $past(insn_i[OPND_MSB:OPND_LSB]))
		else $error("push and call decoded wrongly");

	AST_CTX_SWITCH: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_ctx_switch
		|=> len_bytes_o == LEN_LONG &&
			reg_a_o == $past(insn_i[REG_A_LSB +: GPR_IDX_W]) &&
			operand_o == $past(insn_i[OPND_MSB:OPND_LSB]))
		else $error("context switch decoded wrongly");

	AST_NEAR_RET: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_near_ret
		|=> len_bytes_o == LEN_SHORT && variant_o == $past(dif.alt))
		else $error("near return decoded wrongly");

	AST_SOFT_TRAP: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_soft_trap
		|=> len_bytes_o == LEN_SHORT && dec_class_o == cls_soft_trap)
		else $error("vector call decoded wrongly");

	AST_PREFIX_LEN: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		insn_valid_i && legal && dif.cls == cls_page_prefix
		|=> dec_valid_o && len_bytes_o ==
			($past(insn_i[OPC_LONG_BIT]) ? LEN_LONG : LEN_SHORT))
		else $error("page prefix length wrong");

	AST_ONE_PULSE: assert property (
		@(posedge core_clk_i) disable iff (!resetn_i)
		!insn_valid_i
		|=> !dec_valid_o && !illegal_o)
		else $error("decode flag without an instruction");

endmodule : insn_decoder
`default_nettype wire

/* File: rtl/decoder_pkg.sv */
// constants, class encoding and field layout of the instruction decoder
// ------------------------------------------------------------------------
// Functional notes
// - add/subtract word or byte, with or without carry, 2 or 4 bytes.
// - product_op multiplies GPR by GPR, 16x16, signed or unsigned.
// - short_quotient_op is 2 bytes, divides muldiv_low_reg by a GPR.
// - long_quotient_op divides muldiv_pair_reg by a GPR, 2 bytes.
// - ones/twos complement of a word or byte GPR, 2 bytes each.
// - bit_copy_op copies one bit to another, optionally inverted; 4 bytes.
// - masked_byte_field_modify changes masked high or low byte; 4 bytes.
// - compare_then_decrement compares then decrements GPR by 1 or 2.
// - compare_then_increment compares then increments GPR by 1 or 2.
// - normalize_count_op writes shift count to normalise into second GPR.
// - signed_right_shift shifts GPR right replicating sign; 2 bytes.
// - byte_extend_move widens byte to word with sign or zero fill.
// - branch_on_set_bit jumps if bit is one, variant clears it; 4 bytes.
// - branch_on_clear_bit jumps if bit is zero, variant sets it; 4 bytes.
// - push_then_call pushes a GPR then calls absolute; 4 bytes.
// - context_switch_push saves register then loads word operand; 4 bytes.
// - near_return returns in segment, variant also pops a register.
// - software_vector_call enters service routine by immediate number.
// - legacy_power_down_op decodes as valid 4 bytes but does nothing.
// - every coprocessor operation is encoded in 4 bytes.
// - page_override_prefix opens page, optionally register, sequence.
// ------------------------------------------------------------------------
package decoder_pkg;

	// instruction classes, carried in the top six opcode bits
	typedef enum logic [5:0] {
		cls_nop, cls_add, cls_sub, cls_product, cls_short_quot,
		cls_long_quot, cls_ones_compl, cls_twos_compl, cls_logic,
		cls_bit_set_clr, cls_bit_copy, cls_bit_logic, cls_bit_cmp,
		cls_masked_field, cls_cmp, cls_cmp_dec, cls_cmp_inc,
		cls_norm_count, cls_shift_rot, cls_signed_shr, cls_mov,
		cls_byte_extend, cls_jmp, cls_jmp_seg, cls_br_set_bit,
		cls_br_clr_bit, cls_call, cls_call_seg, cls_push_call,
		cls_soft_trap, cls_push_pop, cls_ctx_switch, cls_near_ret,
		cls_ret_seg, cls_ret_int, cls_soft_break, cls_system,
		cls_atomic, cls_ext_reg, cls_page_prefix, cls_seg_prefix,
		cls_coproc
	} op_class_t;

	// field positions inside the 32-bit instruction word
	localparam int OPC_LONG_BIT  = 0;
	localparam int OPC_ALT_BIT   = 1;
	localparam int OPC_CLASS_LSB = 2;
	localparam int OPC_CLASS_MSB = 7;
	localparam int ARG_LSB       = 8;
	localparam int ARG_MSB       = 15;
	localparam int REG_A_LSB     = 8;
	localparam int REG_B_LSB     = 16;
	localparam int OPND_LSB      = 16;
	localparam int OPND_MSB      = 31;
	// positions inside the argument byte
	localparam int ARG_SUB_LSB   = 4;
	localparam int ARG_SUB_MSB   = 6;
	localparam int ARG_SIZE_BIT  = 7;

	// instruction lengths in bytes
	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_LONG  = 3'h4;
	// register step sizes
	localparam logic [1:0] STEP_ONE  = 2'h1;
	localparam logic [1:0] STEP_TWO  = 2'h2;

	// legal sub-operation counts
	localparam logic [3:0] LOGIC_OPS = 4'h3;	// and, or, xor
	localparam logic [3:0] SYS_OPS   = 4'h7;
	localparam logic [3:0] COP_KINDS = 4'hA;

	// system-control sub-operations
	localparam logic [3:0] SYS_SOFT_RESET = 4'h0;
	localparam logic [3:0] SYS_IDLE       = 4'h1;
	localparam logic [3:0] SYS_LEGACY_PD  = 4'h2;
	localparam logic [3:0] SYS_WDT_SERV   = 4'h3;
	localparam logic [3:0] SYS_WDT_OFF    = 4'h4;
	localparam logic [3:0] SYS_WDT_ON     = 4'h5;
	localparam logic [3:0] SYS_INIT_END   = 4'h6;

endpackage : decoder_pkg

/* File: rtl/decode_if.sv */
// signals shared between the decoder top and its two lookup stages
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
	import decoder_pkg::*;

	logic [7:0] opcode;		// first instruction byte
	logic [7:0] arg;		// second instruction byte
	op_class_t  cls;
	logic       class_ok;	// class exists and length bit fits
	logic       len4;		// four-byte form
	logic       alt;		// opcode variant bit
	logic       field_ok;	// argument byte fits the class
	logic [3:0] sub_kind;	// sub-operation selector
	logic       with_carry;
	logic       signed_op;
	logic [1:0] step;
	logic       sign_fill;
	logic       bit_alter;
	logic       no_effect;
	logic       dividend_pair;

	modport lookup_mp (
		input  opcode,
		output cls, class_ok, len4, alt
	);
	modport variant_mp (
		input  arg, cls, alt,
		output field_ok, sub_kind, with_carry, signed_op, step,
		       sign_fill, bit_alter, no_effect, dividend_pair
	);
	modport top_mp (
		output opcode, arg,
		input  cls, class_ok, len4, alt, field_ok, sub_kind, with_carry,
		       signed_op, step, sign_fill, bit_alter, no_effect,
		       dividend_pair
	);
endinterface : decode_if
`default_nettype wire

/* File: rtl/class_lookup.sv */
// first-byte lookup: class, legality of the length bit, instruction length
`timescale 1ns/100ps
`default_nettype none
module class_lookup (
	decode_if.lookup_mp dif
);
	import decoder_pkg::*;

	logic [5:0] raw_class;
	logic       is_dual;
	logic       is_four;

	// ------------------------------------------------------------
	// length kind per class
	// ------------------------------------------------------------
	assign raw_class = dif.opcode[OPC_CLASS_MSB:OPC_CLASS_LSB];
	assign dif.cls   = op_class_t'(raw_class);
	assign dif.alt   = dif.opcode[OPC_ALT_BIT];

	always_comb begin
		unique case (dif.cls)
			cls_add, cls_sub, cls_logic, cls_cmp, cls_cmp_dec,
			cls_cmp_inc, cls_mov, cls_byte_extend, cls_page_prefix,
			cls_seg_prefix:
				is_dual = 1'b1;
			default:
				is_dual = 1'b0;
		endcase
	end

	always_comb begin
		unique case (dif.cls)
			cls_product, cls_bit_copy, cls_bit_logic, cls_bit_cmp,
			cls_masked_field, cls_norm_count, cls_jmp, cls_jmp_seg,
			cls_br_set_bit, cls_br_clr_bit, cls_call, cls_call_seg,
			cls_push_call, cls_ctx_switch, cls_system, cls_coproc:
				is_four = 1'b1;
			default:
				is_four = 1'b0;
		endcase
	end

	assign dif.len4 = is_dual ? dif.opcode[OPC_LONG_BIT] : is_four;

	// unknown class or wrong length bit
	assign dif.class_ok = (raw_class <= cls_coproc) &&
		(is_dual || (dif.opcode[OPC_LONG_BIT] == is_four));

endmodule : class_lookup
`default_nettype wire

/* File: rtl/variant_decode.sv */
// argument-byte check and per-class variant semantics
`timescale 1ns/100ps
`default_nettype none
module variant_decode (
	decode_if.variant_mp dif
);
	import decoder_pkg::*;

	logic       size_byte;
	logic [3:0] sub;
	logic       sized;

	assign size_byte    = dif.arg[ARG_SIZE_BIT];
	assign sub          = {1'b0, dif.arg[ARG_SUB_MSB:ARG_SUB_LSB]};
	// coprocessor kind uses the size bit as its top bit
	assign dif.sub_kind = (dif.cls == cls_coproc) ? {size_byte, sub[2:0]}
		: sub;

	// ------------------------------------------------------------
	// argument legality
	// ------------------------------------------------------------
	// classes with byte forms
	assign sized = (dif.cls == cls_add) || (dif.cls == cls_sub) ||
		(dif.cls == cls_ones_compl) || (dif.cls == cls_twos_compl) ||
		(dif.cls == cls_logic) || (dif.cls == cls_cmp) ||
		(dif.cls == cls_mov);

	always_comb begin
		unique case (dif.cls)
			cls_logic:
				dif.field_ok = sub < LOGIC_OPS;
			cls_bit_logic:
				dif.field_ok = !size_byte && (sub < LOGIC_OPS);
			cls_shift_rot:
				dif.field_ok = !size_byte;
			cls_system:
				dif.field_ok = !size_byte && (sub < SYS_OPS);
			cls_coproc:
				dif.field_ok = ({size_byte, sub[2:0]} < COP_KINDS);
			default:
				dif.field_ok = (sub == 4'h0) && (sized || !size_byte);
		endcase
	end

	// ------------------------------------------------------------
	// variant semantics
	// ------------------------------------------------------------
	// carry input
	assign dif.with_carry = ((dif.cls == cls_add) || (dif.cls == cls_sub))
		&& dif.alt;
	assign dif.signed_op = ((dif.cls == cls_product) ||
		(dif.cls == cls_short_quot) || (dif.cls == cls_long_quot)) &&
		!dif.alt;
	assign dif.dividend_pair = (dif.cls == cls_long_quot);
	assign dif.step = ((dif.cls == cls_cmp_dec) || (dif.cls == cls_cmp_inc))
		? (dif.alt ? STEP_TWO : STEP_ONE) : 2'h0;
	assign dif.sign_fill = (dif.cls == cls_signed_shr) ||
		((dif.cls == cls_byte_extend) && !dif.alt);
	// invert, clear or set the addressed bit
	assign dif.bit_alter = ((dif.cls == cls_bit_copy) ||
		(dif.cls == cls_br_set_bit) || (dif.cls == cls_br_clr_bit)) &&
		dif.alt;
	assign dif.no_effect = (dif.cls == cls_system) && (sub == SYS_LEGACY_PD);

endmodule : variant_decode
`default_nettype wire

/* File: tb/fetch_model.sv */
// fetch-side model: presents instruction words and follows the length
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        dec_valid_i,
	input  wire logic [2:0]  len_i,
	output var  logic        insn_valid_o,
	output var  logic [31:0] insn_o,
	output var  logic [15:0] ip_o
);
	logic [31:0] last;

	initial begin
		insn_valid_o = 1'b0;
		insn_o = 32'h0;
		last = 32'h0;
	end

	// present one word, changed at the falling edge
	task present(input logic [31:0] w);
		@(negedge core_clk_i);
		insn_valid_o = 1'b1;
		insn_o = w;
		last = w;
	endtask : present

	// idle cycle: the bus shows the inverse so stale data is never trusted
	task idle();
		@(negedge core_clk_i);
		insn_valid_o = 1'b0;
		insn_o = ~last;
	endtask : idle

	// ----------------------------------------------------------------
	// instruction pointer
	// ----------------------------------------------------------------
	// ip follows length
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			ip_o <= 16'h0;
		else if (dec_valid_i)
			ip_o <= ip_o + {13'h0, len_i};
	end
endmodule : fetch_model
`default_nettype wire

/* File: tb/insn_decoder_tb.sv */
// self-checking testbench of the instruction decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module insn_decoder_tb;
	import decoder_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        insn_valid_i;
	logic [31:0] insn_i;
	logic        dec_valid_o, illegal_o, byte_op_o, variant_o;
	logic        with_carry_o, signed_op_o, dividend_pair_o;
	logic        sign_fill_o, bit_alter_o, no_effect_o;
	op_class_t   dec_class_o;
	logic [2:0]  len_bytes_o;
	logic [3:0]  sub_kind_o, reg_a_o, reg_b_o;
	logic [1:0]  step_o;
	logic [15:0] operand_o, ip;
	int          mismatches = 0;
	int          n_tests = 0;

	always #12.5 core_clk_i = ~core_clk_i;

	insn_decoder #(.GPR_IDX_W(4)) dut (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
		.dec_valid_o(dec_valid_o), .illegal_o(illegal_o),
		.dec_class_o(dec_class_o), .len_bytes_o(len_bytes_o),
		.byte_op_o(byte_op_o), .variant_o(variant_o),
		.sub_kind_o(sub_kind_o), .with_carry_o(with_carry_o),
		.signed_op_o(signed_op_o), .dividend_pair_o(dividend_pair_o),
		.step_o(step_o), .sign_fill_o(sign_fill_o),
		.bit_alter_o(bit_alter_o), .no_effect_o(no_effect_o),
		.reg_a_o(reg_a_o), .reg_b_o(reg_b_o), .operand_o(operand_o));

	fetch_model fetch (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.dec_valid_i(dec_valid_o), .len_i(len_bytes_o),
		.insn_valid_o(insn_valid_i), .insn_o(insn_i), .ip_o(ip));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] mk(op_class_t c, logic alt, logic lng,
			logic [7:0] arg, logic [15:0] hi);
		return {hi, arg, c, alt, lng};
	endfunction : mk

	function automatic logic [2:0] ln(logic lng);
		return lng ? LEN_LONG : LEN_SHORT;
	endfunction : ln

	// one isolated instruction, judged at the next falling edge after it is taken
	task run(input logic [31:0] w, input logic ok, input logic [2:0] len);
		fetch.present(w);
		fetch.idle();
		`CHK(dec_valid_o, ok)
		`CHK(illegal_o, !ok)
		if (ok)
			`CHK(len_bytes_o, len)
	endtask : run

	task summarize();
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_arith();
		for (int i = 0; i < 16; i++) begin
			run(mk(i[3] ? cls_sub : cls_add, i[2], i[1], {i[0], 7'h05},
				16'hA5C3), 1'b1, ln(i[1]));
			`CHK(with_carry_o, i[2])
			`CHK(byte_op_o, i[0])
			`CHK(operand_o, i[1] ? 16'hA5C3 : 16'h0)
			`CHK(reg_a_o, 4'h5)
		end
	endtask : t_arith

	task t_muldiv();
		for (int a = 0; a < 2; a++) begin
			run(mk(cls_product, a[0], 1'b1, 8'h03, 16'h0007), 1'b1, LEN_LONG);
			`CHK(signed_op_o, !a[0])
			`CHK(reg_b_o, 4'h7)
			run(mk(cls_short_quot, a[0], 1'b0, 8'h04, 16'h0), 1'b1, LEN_SHORT);
			`CHK(signed_op_o, !a[0])
			`CHK(dividend_pair_o, 1'b0)
			run(mk(cls_long_quot, a[0], 1'b0, 8'h06, 16'h0), 1'b1, LEN_SHORT);
			`CHK(signed_op_o, !a[0])
			`CHK(dividend_pair_o, 1'b1)
		end
		run(mk(cls_short_quot, 1'b0, 1'b1, 8'h04, 16'h0), 1'b0, LEN_LONG);
		run(mk(cls_product, 1'b0, 1'b1, 8'h83, 16'h0), 1'b0, LEN_LONG);
	endtask : t_muldiv

	task t_compl();
		for (int i = 0; i < 4; i++) begin
			run(mk(i[1] ? cls_twos_compl : cls_ones_compl, 1'b0, 1'b0,
				{i[0], 7'h02}, 16'h0), 1'b1, LEN_SHORT);
			`CHK(byte_op_o, i[0])
		end
		run(mk(cls_ones_compl, 1'b0, 1'b1, 8'h02, 16'h0), 1'b0, LEN_LONG);
		run(mk(cls_logic, 1'b0, 1'b0, 8'hA1, 16'h0), 1'b1, LEN_SHORT);
		`CHK(byte_op_o, 1'b1)
		run(mk(cls_logic, 1'b0, 1'b0, 8'h31, 16'h0), 1'b0, LEN_SHORT);
		run(mk(cls_shift_rot, 1'b0, 1'b0, 8'h71, 16'h0), 1'b1, LEN_SHORT);
		`CHK(sub_kind_o, 4'h7)
	endtask : t_compl

	task t_bits();
		op_class_t bc[4];
		bc = '{cls_bit_copy, cls_br_set_bit, cls_br_clr_bit, cls_masked_field};
		for (int i = 0; i < 8; i++) begin
			run(mk(bc[i/2], i[0], 1'b1, 8'h01, 16'h1234), 1'b1, LEN_LONG);
			`CHK(variant_o, i[0])
			if (i < 6)
				`CHK(bit_alter_o, i[0])
			else
				`CHK(bit_alter_o, 1'b0)
		end
		run(mk(cls_br_set_bit, 1'b0, 1'b0, 8'h01, 16'h0), 1'b0, LEN_SHORT);
		run(mk(cls_br_clr_bit, 1'b1, 1'b0, 8'h01, 16'h0), 1'b0, LEN_SHORT);
	endtask : t_bits

	task t_step();
		for (int i = 0; i < 8; i++) begin
			run(mk(i[2] ? cls_cmp_inc : cls_cmp_dec, i[1], i[0], 8'h09,
				16'h0), 1'b1, ln(i[0]));
			`CHK(step_o, i[1] ? STEP_TWO : STEP_ONE)
		end
	endtask : t_step

	task t_shift();
		run(mk(cls_norm_count, 1'b0, 1'b1, 8'h0A, 16'h000B), 1'b1, LEN_LONG);
		`CHK(reg_a_o, 4'hA)
		`CHK(reg_b_o, 4'hB)
		run(mk(cls_signed_shr, 1'b0, 1'b0, 8'h0C, 16'h0), 1'b1, LEN_SHORT);
		`CHK(sign_fill_o, 1'b1)
		run(mk(cls_signed_shr, 1'b0, 1'b1, 8'h0C, 16'h0), 1'b0, LEN_LONG);
		for (int i = 0; i < 4; i++) begin
			run(mk(cls_byte_extend, i[1], i[0], 8'h01, 16'h0), 1'b1,
				ln(i[0]));
			`CHK(sign_fill_o, !i[1])
		end
	endtask : t_shift

	task t_flow();
		run(mk(cls_push_call, 1'b0, 1'b1, 8'h02, 16'h8001), 1'b1, LEN_LONG);
		`CHK(operand_o, 16'h8001)
		run(mk(cls_ctx_switch, 1'b0, 1'b1, 8'h03, 16'h7FFE), 1'b1, LEN_LONG);
		`CHK(operand_o, 16'h7FFE)
		`CHK(reg_a_o, 4'h3)
		for (int a = 0; a < 2; a++) begin
			run(mk(cls_near_ret, a[0], 1'b0, 8'h04, 16'h0), 1'b1, LEN_SHORT);
			`CHK(variant_o, a[0])
		end
		run(mk(cls_soft_trap, 1'b0, 1'b0, 8'h0F, 16'h0), 1'b1, LEN_SHORT);
		`CHK(reg_a_o, 4'hF)
		`CHK(dec_class_o, cls_soft_trap)
	endtask : t_flow

	task t_system();
		for (int s = 0; s < 8; s++) begin
			run(mk(cls_system, 1'b0, 1'b1, {1'b0, s[2:0], 4'h0}, 16'h0),
				s < 7, LEN_LONG);
			if (s < 7)
				`CHK(no_effect_o, s == 2)
		end
	endtask : t_system

	task t_coproc();
		for (int k = 0; k < 11; k++) begin
			run(mk(cls_coproc, 1'b0, 1'b1, {k[3:0], 4'h1}, 16'h0), k < 10,
				LEN_LONG);
			if (k < 10)
				`CHK(sub_kind_o, k[3:0])
		end
		run(mk(cls_coproc, 1'b0, 1'b0, 8'h01, 16'h0), 1'b0, LEN_SHORT);
	endtask : t_coproc

	task t_prefix();
		for (int i = 0; i < 4; i++) begin
			run(mk(cls_page_prefix, i[1], i[0], 8'h00, 16'h0), 1'b1,
				ln(i[0]));
			`CHK(variant_o, i[1])
		end
	endtask : t_prefix

	// back-to-back stream with illegal words, then a reset in mid-run
	task t_stream();
		logic [15:0] ip0;
		fetch.idle();
		ip0 = ip;
		fetch.present(mk(cls_add, 1'b0, 1'b1, 8'h01, 16'h0));
		fetch.present(mk(cls_add, 1'b0, 1'b1, 8'h82, 16'h0001));
		fetch.present(32'h0000_00FC);
		`CHK(dec_valid_o, 1'b1)
		`CHK(len_bytes_o, LEN_LONG)
		fetch.present(mk(cls_soft_trap, 1'b0, 1'b0, 8'h02, 16'h0));
		`CHK(illegal_o, 1'b1)
		`CHK(dec_valid_o, 1'b0)
		fetch.present(32'h0000_00A9);
		`CHK(len_bytes_o, LEN_SHORT)
		fetch.idle();
		`CHK(illegal_o, 1'b1)
		fetch.idle();
		`CHK(ip, ip0 + 16'h000A)
		fetch.present(mk(cls_add, 1'b0, 1'b1, 8'h01, 16'hFFFF));
		@(negedge core_clk_i);
		resetn_i = 1'b0;
		fetch.idle();
		`CHK(dec_valid_o, 1'b0)
		`CHK(len_bytes_o, LEN_SHORT)
		`CHK(operand_o, 16'h0)
		`CHK(dec_class_o, cls_nop)
		resetn_i = 1'b1;
		run(mk(cls_sub, 1'b1, 1'b0, 8'h03, 16'h0), 1'b1, LEN_SHORT);
		`CHK(with_carry_o, 1'b1)
	endtask : t_stream

	initial begin
		repeat (20) @(negedge core_clk_i);
		resetn_i = 1'b1;
		t_arith();
		t_muldiv();
		t_compl();
		t_bits();
		t_step();
		t_shift();
		t_flow();
		t_system();
		t_coproc();
		t_prefix();
		t_stream();
		summarize();
	end

	// watchdog: the run needs well under a thousand cycles
	initial begin
		#(25 * 5000);
		mismatches++;
		summarize();
	end
endmodule : insn_decoder_tb
`default_nettype wire
